// file: src/ppg_one_bit_modulation_ctrl.sv
// 1-bit modulation control for one timer of a paired ppg timer
`timescale 1ns/1ns
`include "ppg_mod_params.svh"

module ppg_one_bit_modulation_ctrl
   import ppg_mod_pkg::*;
(
   input wire logic clk, // peripheral clock, 10 MHz
   input wire logic sys_rst, // async reset, active high
   input wire logic [`ADDR_W-1:0] reg_addr, // register byte address
   input wire logic [31:0] reg_wdata, // register write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   output logic [31:0] reg_rdata, // read data, cycle after reg_rd
   input wire logic ppg_mode, // timer in ppg or interlock ppg mode
   input wire logic counter_clear_en, // first timer clears on period match
   input wire logic counter_overflow, // first up-counter overflow pulse
   input wire logic first_period_match, // first timer period compare match pulse
   input wire logic period_match, // this timer period compare match pulse
   output logic compare_buf_en, // compare writes go through buffers
   output logic [`MULT_W-1:0] ch0_mod_mult, // channel-0 period cycles per modulation cycle
   output logic [`MULT_W-1:0] ch1_mod_mult, // channel-1 period cycles per modulation cycle
   output logic ch0_reload, // reload channel-0 compares from buffers
   output logic ch1_reload // reload ch1_compare_a and ch1_compare_b
);

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   // forbidden codes are treated as no modulation rather than guessing a count
   function automatic logic [`MULT_W-1:0] mult_of(input logic [2:0] code);
      case (mod_cycle_t'(code))
         MOD_X2: mult_of = `MULT_X2;
         MOD_X4: mult_of = `MULT_X4;
         MOD_X8: mult_of = `MULT_X8;
         MOD_X16: mult_of = `MULT_X16;
         default: mult_of = `MULT_ONE;
      endcase
   endfunction

   // ----------------------------------------
   // register slave
   // ----------------------------------------
   logic [`CTRL_W-1:0] wr_q; // last value written by software
   logic [`CTRL_W-1:0] wr_d;
   logic [`CTRL_W-1:0] active_q; // value in effect
   logic [`CTRL_W-1:0] active_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;

   wire sel_ctrl = (reg_addr == `OFS_CTRL);
   wire sel_stat = (reg_addr == `OFS_STAT);
   wire ctrl_write = reg_wr & sel_ctrl;

   // unused and upper bits are masked off on the way in
   assign wr_d = ctrl_write ? (reg_wdata[`CTRL_W-1:0] & `CTRL_WMASK) : wr_q;

   // a write is held back until the first timer's period boundary
   wire xfer = counter_clear_en ? first_period_match : counter_overflow;
   assign active_d = xfer ? wr_d : active_q;

   // reads return written value or value in effect; unmapped reads give zero
   assign rdata_d = !reg_rd ? `RDATA_RST :
                    sel_ctrl ? {{(32-`CTRL_W){1'b0}}, wr_q} :
                    sel_stat ? {{(32-`CTRL_W){1'b0}}, active_q} :
                    `RDATA_RST;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_q <= `CTRL_RST;
         active_q <= `CTRL_RST;
         rdata_q <= `RDATA_RST;
      end else begin
         wr_q <= wr_d;
         active_q <= active_d;
         rdata_q <= rdata_d;
      end
   end

   assign reg_rdata = rdata_q;

   // ----------------------------------------
   // field extraction
   // ----------------------------------------
   logic [2:0] cyc_sel [2];
   logic timing_sel [2];
   logic [`MULT_W-1:0] mult_q [2];
   logic reload [2];
   logic cyc_end [2];
   logic mod_on [2];

   assign cyc_sel[0] = active_q[`CH0_CYC_MSB:`CH0_CYC_LSB];
   assign cyc_sel[1] = active_q[`CH1_CYC_MSB:`CH1_CYC_LSB];
   assign timing_sel[0] = active_q[`CH0_PT_BIT];
   assign timing_sel[1] = active_q[`CH1_PT_BIT];
   wire buf_en = active_q[`BUF_EN_BIT];

   // buffered path only means anything in the ppg modes
   assign compare_buf_en = buf_en & ppg_mode;

   // ----------------------------------------
   // per-channel modulation and reload timing
   // ----------------------------------------
   for (genvar c = 0; c < 2; c++) begin : g_ch
      wire [`MULT_W-1:0] mult = mult_of(cyc_sel[c]);
      wire [`MULT_W-1:0] mult_minus = mult - `MULT_ONE;
      wire [`MULT_W-1:0] mult_eff = ppg_mode ? mult : `MULT_ONE;

      // modulation is off outside ppg modes even if a code is stored
      assign mod_on[c] = ppg_mode & (mult != `MULT_ONE);

      mod_cycle_counter u_cnt (
         .clk(clk),
         .sys_rst(sys_rst),
         .enable(mod_on[c]),
         .period_match(period_match),
         .limit(mult_minus[`CNT_W-1:0]),
         .cycle_end(cyc_end[c])
      );

      // no modulation behaves like timing bit 1: reload on each match
      wire on_match = ~mod_on[c] | timing_sel[c];
      assign reload[c] = compare_buf_en & (on_match ? period_match : cyc_end[c]);

      // multiplier held in a flop so the data output is glitch free
      always_ff @(posedge clk or posedge sys_rst) begin
         if (sys_rst) begin
            mult_q[c] <= `MULT_ONE;
         end else begin
            mult_q[c] <= mult_eff;
         end
      end
   end

   assign ch0_mod_mult = mult_q[0];
   assign ch1_mod_mult = mult_q[1];
   assign ch0_reload = reload[0];
   assign ch1_reload = reload[1];

   // ----------------------------------------
   // checks
   // ----------------------------------------
   a_xfer_overflow: assert property (@(posedge clk) disable iff (sys_rst)
      !counter_clear_en && counter_overflow |=> active_q == $past(wr_d))
      else $error("setting not taken on overflow");

   a_xfer_match: assert property (@(posedge clk) disable iff (sys_rst)
      counter_clear_en && first_period_match |=> active_q == $past(wr_d))
      else $error("setting not taken on period match");

   a_hold_setting: assert property (@(posedge clk) disable iff (sys_rst)
      !xfer |=> $stable(active_q))
      else $error("setting changed between boundaries");

   a_reload_nomod: assert property (@(posedge clk) disable iff (sys_rst)
      ppg_mode && buf_en && cyc_sel[1] == 3'h0 && period_match |-> ch1_reload)
      else $error("no-modulation reload missing on match");

   a_reload_cycle: assert property (@(posedge clk) disable iff (sys_rst)
      compare_buf_en && mod_on[1] && !timing_sel[1] |-> ch1_reload == cyc_end[1])
      else $error("ch1 reload not at modulation cycle end");

   a_reload_direct: assert property (@(posedge clk) disable iff (sys_rst)
      !buf_en || !ppg_mode |-> !ch0_reload && !ch1_reload)
      else $error("reload while compare writes are direct");

   a_timer_mode: assert property (@(posedge clk) disable iff (sys_rst)
      !ppg_mode |=> ch0_mod_mult == 5'h01 && ch1_mod_mult == 5'h01)
      else $error("modulation active in timer mode");

   a_ch1_x16: assert property (@(posedge clk) disable iff (sys_rst)
      ppg_mode && cyc_sel[1] == 3'h4 |=> ch1_mod_mult == 5'h10)
      else $error("ch1 x16 multiplier wrong");

   a_ch0_x2: assert property (@(posedge clk) disable iff (sys_rst)
      ppg_mode && cyc_sel[0] == 3'h1 |=> ch0_mod_mult == 5'h02)
      else $error("ch0 x2 multiplier wrong");

   a_upper_zero: assert property (@(posedge clk) disable iff (sys_rst)
      reg_rd && sel_ctrl |=> reg_rdata[31:12] == 20'h00000 && reg_rdata[3] == 1'b0)
      else $error("reserved bits read nonzero");

   // follows the buffer bit through the transfer, not just the local expression
   a_buf_path: assert property (@(posedge clk) disable iff (sys_rst)
      xfer ##1 ppg_mode |-> compare_buf_en == $past(wr_d[`BUF_EN_BIT]))
      else $error("buffer path flag wrong");

endmodule

// file: src/ppg_mod_params.svh
// named offsets, field positions, reset values and counts of the modulation control block
`ifndef PPG_MOD_PARAMS_SVH
`define PPG_MOD_PARAMS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define ADDR_W 4
`define OFS_CTRL 4'h0
`define OFS_STAT 4'h4

// ----------------------------------------
// field positions of timer_modulation_control
// ----------------------------------------
`define CH1_CYC_MSB 11
`define CH1_CYC_LSB 9
`define CH1_PT_BIT 8
`define CH0_CYC_MSB 7
`define CH0_CYC_LSB 5
`define CH0_PT_BIT 4
`define BUF_EN_BIT 2
`define CTRL_W 12

// ----------------------------------------
// reset values and masks
// ----------------------------------------
`define CTRL_RST 12'h000
`define CTRL_WMASK 12'hFF4
`define RDATA_RST 32'h0000_0000

// ----------------------------------------
// modulation counts
// ----------------------------------------
`define MULT_W 5
`define MULT_ONE 5'h01
`define MULT_X2 5'h02
`define MULT_X4 5'h04
`define MULT_X8 5'h08
`define MULT_X16 5'h10
`define CNT_W 4
`define CNT_RST 4'h0
`define CNT_STEP 4'h1

`endif

// file: src/ppg_mod_pkg.sv
// types shared by the modulation control block
package ppg_mod_pkg;

   // ----------------------------------------
   // modulation cycle encodings
   // ----------------------------------------
   typedef enum logic [2:0] {
      MOD_NONE = 3'b000,
      MOD_X2 = 3'b001,
      MOD_X4 = 3'b010,
      MOD_X8 = 3'b011,
      MOD_X16 = 3'b100
   } mod_cycle_t;

endpackage

// file: src/mod_cycle_counter.sv
// counts period-compare matches and marks the end of each modulation cycle
`timescale 1ns/1ns
`include "ppg_mod_params.svh"

module mod_cycle_counter
   import ppg_mod_pkg::*;
(
   input wire logic clk, // peripheral clock
   input wire logic sys_rst, // async reset, active high
   input wire logic enable, // modulation running on this channel
   input wire logic period_match, // period compare match pulse
   input wire logic [`CNT_W-1:0] limit, // matches per modulation cycle minus one
   output logic cycle_end // last match of a modulation cycle
);

   logic [`CNT_W-1:0] cnt_q;
   logic [`CNT_W-1:0] cnt_d;
   wire at_limit = (cnt_q == limit);

   // count wraps on the last match; disabled channel restarts from zero
   assign cycle_end = enable & period_match & at_limit;
   assign cnt_d = !enable ? `CNT_RST :
                  cycle_end ? `CNT_RST :
                  period_match ? cnt_q + `CNT_STEP : cnt_q;

   // match counter
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         cnt_q <= `CNT_RST;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // limit is at least one, so two cycle ends never touch
   sequence s_end;
      cycle_end;
   endsequence
   property p_end_spacing;
      @(posedge clk) disable iff (sys_rst) s_end |=> !cycle_end;
   endproperty
   a_end_spacing: assert property (p_end_spacing) else $error("cycle end on two adjacent cycles");

endmodule

// file: tb/test_ppg_one_bit_modulation_ctrl.sv
// self-checking bench of the 1-bit modulation control block
`timescale 1ns/1ns
`include "ppg_mod_params.svh"

module test_ppg_one_bit_modulation_ctrl;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [`ADDR_W-1:0] reg_addr = '0;
   logic [31:0] reg_wdata = '0;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [31:0] reg_rdata;
   logic ppg_mode = 1'b1;
   logic counter_clear_en = 1'b0;
   logic counter_overflow = 1'b0;
   logic first_period_match = 1'b0;
   logic period_match = 1'b0;
   logic compare_buf_en;
   logic [`MULT_W-1:0] ch0_mod_mult;
   logic [`MULT_W-1:0] ch1_mod_mult;
   logic ch0_reload;
   logic ch1_reload;
   int fails = 0;
   int samples_checked = 0;

   // ----------------------------------------
   // clock and device
   // ----------------------------------------
   always #50 clk = ~clk;

   ppg_one_bit_modulation_ctrl u_dut (
      .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ppg_mode(ppg_mode),
      .counter_clear_en(counter_clear_en), .counter_overflow(counter_overflow),
      .first_period_match(first_period_match), .period_match(period_match),
      .compare_buf_en(compare_buf_en), .ch0_mod_mult(ch0_mod_mult), .ch1_mod_mult(ch1_mod_mult),
      .ch0_reload(ch0_reload), .ch1_reload(ch1_reload));

   // ----------------------------------------
   // access and compare tasks
   // ----------------------------------------
   // case equality so an unknown never passes
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1;
      chk(reg_rdata, exp);
   endtask

   // one transfer pulse, then one more edge for the registered multipliers
   task automatic xfer(input logic ovf);
      @(posedge clk);
      counter_overflow <= ovf;
      first_period_match <= !ovf;
      @(posedge clk);
      counter_overflow <= 1'b0;
      first_period_match <= 1'b0;
      @(posedge clk);
      #1;
   endtask

   // reload outputs are combinational, looked at while the match is high
   task automatic match(input logic e1, input logic e0);
      @(posedge clk);
      period_match <= 1'b1;
      #1;
      chk({31'h0, ch1_reload}, {31'h0, e1});
      chk({31'h0, ch0_reload}, {31'h0, e0});
      @(posedge clk);
      period_match <= 1'b0;
   endtask

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // tests
   // ----------------------------------------
   initial begin
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      rchk(`OFS_CTRL, 32'h0);
      chk({27'h0, ch1_mod_mult}, 32'h1);
      chk({27'h0, ch0_mod_mult}, 32'h1);
      chk({31'h0, compare_buf_en}, 32'h0);
      chk({30'h0, ch1_reload, ch0_reload}, 32'h0);
      $display("test reset done");
      // reserved bits set, cycle fields kept at a legal code
      wr(`OFS_CTRL, 32'hFFFF_F99F);
      rchk(`OFS_CTRL, 32'h0000_0994);
      rchk(`OFS_STAT, 32'h0);
      wr(4'h8, 32'hFFFF_FFFF);
      rchk(4'h8, 32'h0);
      $display("test register access done");
      // transfer event follows the clear enable
      @(posedge clk);
      counter_clear_en <= 1'b1;
      wr(`OFS_CTRL, 32'h0000_0824);
      xfer(1'b1);
      rchk(`OFS_STAT, 32'h0);
      xfer(1'b0);
      rchk(`OFS_STAT, 32'h0000_0824);
      @(posedge clk);
      counter_clear_en <= 1'b0;
      wr(`OFS_CTRL, 32'h0000_0424);
      xfer(1'b0);
      rchk(`OFS_STAT, 32'h0000_0824);
      xfer(1'b1);
      rchk(`OFS_STAT, 32'h0000_0424);
      $display("test transfer done");
      // every legal cycle code; equal codes on both channels suit a paired partner timer
      for (int k = 0; k < 5; k++) begin
         wr(`OFS_CTRL, (k << 9) | (k << 5) | 32'h4);
         xfer(1'b1);
         chk({27'h0, ch1_mod_mult}, 32'h1 << k);
         chk({27'h0, ch0_mod_mult}, 32'h1 << k);
      end
      $display("test cycle codes done");
      // timer mode masks all settings
      @(posedge clk);
      ppg_mode <= 1'b0;
      repeat (2) @(posedge clk);
      #1;
      chk({27'h0, ch1_mod_mult}, 32'h1);
      chk({27'h0, ch0_mod_mult}, 32'h1);
      chk({31'h0, compare_buf_en}, 32'h0);
      match(1'b0, 1'b0);
      @(posedge clk);
      ppg_mode <= 1'b1;
      $display("test timer mode done");
      // reload timing
      wr(`OFS_CTRL, 32'h0000_0004);
      xfer(1'b1);
      repeat (2) match(1'b1, 1'b1);
      wr(`OFS_CTRL, 32'h0000_0224);
      xfer(1'b1);
      for (int i = 1; i <= 4; i++) match(i % 2 == 0, i % 2 == 0);
      // longest and a middle cycle: ch1 x16, ch0 x4, both reload at cycle end
      wr(`OFS_CTRL, 32'h0000_0844);
      xfer(1'b1);
      for (int i = 1; i <= 16; i++) match(i % 16 == 0, i % 4 == 0);
      wr(`OFS_CTRL, 32'h0000_0334);
      xfer(1'b1);
      repeat (2) match(1'b1, 1'b1);
      wr(`OFS_CTRL, 32'h0000_0330);
      xfer(1'b1);
      chk({31'h0, compare_buf_en}, 32'h0);
      match(1'b0, 1'b0);
      $display("test reload timing done");
      stop_test();
   end

   // the tests need some 150 cycles; forty times that is a hang
   initial begin
      #600000;
      fails++;
      stop_test();
   end
endmodule
